// ===== rtl/rc_reset_ctrl.v
// reset controller top: pin manager, startup counter, reset state manager, registers
//
// Overview of operation
// - everything runs on the one slow clock, outputs other than the constant ext_reset_pin_o are flip-flops on it
// - processor reset covers core and peripherals; backup reset covers backup domain
// - resets come from supplies, the pin or software; the state machine decides
// - mode register survives every reset except loss of the backup supply and resetn_i low
// - pin sampled on the clock; a falling edge in the run state reports a user reset
// - the pin is driven low whenever the state machine asks for it
// - user reset enable cleared means the pin no longer triggers a reset
// - the pin level is always readable in the status register
// - user reset status sets on pin assertion and clears only on status read
// - with interrupt enable set, pin assertion raises an interrupt, not a reset
// - reset cause field is updated when processor reset is released
// - general reset on power up, filtered through the fixed startup counter
// - startup delay equals the worst-case oscillator startup time
// - after startup, clock runs while resets hold two cycles, then general cause
// - backup supply low asserts every reset output at once
// - the core supply by itself only drives the processor reset
// - core supply resets are ignored while backup reset is asserted
//
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "rc_map.vh"
module rc_reset_ctrl #(
   parameter STARTUP_CYC = `RC_STARTUP_CYC,
   parameter [7:0] PIN_DRIVE_CYC = `RC_PIN_DRIVE_CYC
) (
   // clock and reset
   input wire clock_i,
   input wire resetn_i,
   // supply detectors, high while the supply is good
   input wire backup_por_i,
   input wire core_por_i,
   // external reset pin, open drain
   input wire ext_reset_pin_i,
   output wire ext_reset_pin_o,
   output wire ext_reset_pin_oe_o,
   // generated resets and processor clock release
   output wire proc_reset_n_o,
   output wire backup_reset_n_o,
   output wire proc_clk_en_o,
   // register port
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output wire [31:0] rdata_o,
   // interrupt
   output wire irq_o
);
   localparam [3:0] ST_STARTUP = 4'b0001;
   localparam [3:0] ST_HOLD = 4'b0010;
   localparam [3:0] ST_RUN = 4'b0100;
   localparam [3:0] ST_ASSERT = 4'b1000;

   wire rst_n;
   wire bk_rst_n;
   wire core_ok;
   wire pin_lvl;
   wire start_done;
   wire [1:0] sync_q;

   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg [2:0] pend_reg;
   reg [2:0] pend_next;
   reg [1:0] hold_reg;
   reg [1:0] hold_next;
   reg [7:0] drive_reg;
   reg [7:0] drive_next;
   reg pin_prev_reg;
   reg proc_rst_n_reg;
   reg bk_rst_n_reg;
   reg clk_en_reg;
   reg pin_oe_reg;
   reg [2:0] cause_reg;
   reg user_stat_reg;
   reg user_stat_next;
   reg [1:0] mode_reg;
   reg [`RC_IRQ_N-1:0] irq_mask_reg;
   wire [`RC_IRQ_N-1:0] irq_stat;
   wire [`RC_IRQ_N-1:0] irq_stat_next;
   wire [`RC_IRQ_N-1:0] irq_ev;
   reg irq_reg;
   reg [31:0] rdata_reg;
   reg [31:0] rdata_next;

   // reset release through two flip-flops; backup loss asserts it at once,
   // its release is retimed so no flop leaves reset on a clock edge race
   rc_sync2 #(
      .WIDTH(1),
      .RST_VAL(1'b0)
   ) u_rst_sync (
      .clock_i(clock_i),
      .rst_n_i(resetn_i & backup_por_i),
      .d_i(1'b1),
      .q_o(rst_n)
   );

   // backup low
   // backup supply loss clears every output flop without waiting for a clock
   assign bk_rst_n = rst_n & backup_por_i;

   // pin synchroniser
   // bit 1 core detector, bit 0 pin; pin idles high
   rc_sync2 #(
      .WIDTH(2),
      .RST_VAL(2'b01)
   ) u_in_sync (
      .clock_i(clock_i),
      .rst_n_i(bk_rst_n),
      .d_i({core_por_i, ext_reset_pin_i}),
      .q_o(sync_q)
   );
   assign core_ok = sync_q[1];
   assign pin_lvl = sync_q[0];

   rc_startup_cnt #(
      .CYC(STARTUP_CYC)
   ) u_startup (
      .clock_i(clock_i),
      .rst_n_i(bk_rst_n),
      .run_i(state_reg == ST_STARTUP),
      .done_o(start_done)
   );

   wire pin_fall = pin_prev_reg & ~pin_lvl;
   wire in_run = (state_reg == ST_RUN);
   wire uren = mode_reg[0];
   wire uien = mode_reg[1];
   wire user_req = in_run & pin_fall & uren & ~uien;
   wire user_irq = in_run & pin_fall & uien;

   wire wr_ctrl = wr_i & (addr_i == `RC_OFF_CTRL);
   wire wr_mode = wr_i & (addr_i == `RC_OFF_MODE);
   wire wr_istat = wr_i & (addr_i == `RC_OFF_IRQ_STAT);
   wire wr_imask = wr_i & (addr_i == `RC_OFF_IRQ_MASK);
   wire rd_stat = rd_i & (addr_i == `RC_OFF_STAT);
   wire soft_req = wr_ctrl & wdata_i[`RC_CTRL_PROC_RST];
   wire soft_pin = wdata_i[`RC_CTRL_EXT_RST];

   always @* begin
      state_next = state_reg;
      pend_next = pend_reg;
      hold_next = hold_reg;
      drive_next = drive_reg;
      case (state_reg)
         ST_STARTUP: begin
            pend_next = `RC_CAUSE_GENERAL;
            if (start_done) begin
               state_next = ST_HOLD;
               hold_next = `RC_HOLD_CYC - 2'd1;
            end
         end
         ST_HOLD: begin
            if (hold_reg == 2'd0) begin
               state_next = ST_RUN;
            end else begin
               hold_next = hold_reg - 2'd1;
            end
         end
         ST_RUN: begin
            if (!core_ok) begin
               state_next = ST_ASSERT;
               pend_next = `RC_CAUSE_CORE;
               drive_next = 8'h00;
            end else if (user_req) begin
               state_next = ST_ASSERT;
               pend_next = `RC_CAUSE_USER;
               drive_next = 8'h00;
            end else if (soft_req) begin
               state_next = ST_ASSERT;
               pend_next = `RC_CAUSE_SOFT;
               drive_next = soft_pin ? PIN_DRIVE_CYC : 8'h00;
            end
         end
         ST_ASSERT: begin
            // stay until own drive ends, pin is high and core supply is good
            if (drive_reg != 8'h00) begin
               drive_next = drive_reg - 8'h01;
            end else if (core_ok && pin_lvl) begin
               state_next = ST_HOLD;
               hold_next = `RC_HOLD_CYC - 2'd1;
            end
         end
         default: begin
            state_next = ST_STARTUP;
         end
      endcase
   end

   always @(posedge clock_i or negedge bk_rst_n) begin
      if (!bk_rst_n) begin
         state_reg <= ST_STARTUP;
         pend_reg <= `RC_CAUSE_GENERAL;
         hold_reg <= 2'd0;
         drive_reg <= 8'h00;
         pin_prev_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         pend_reg <= pend_next;
         hold_reg <= hold_next;
         drive_reg <= drive_next;
         pin_prev_reg <= pin_lvl;
      end
   end

   always @(posedge clock_i or negedge bk_rst_n) begin
      if (!bk_rst_n) begin
         proc_rst_n_reg <= 1'b0;
         bk_rst_n_reg <= 1'b0;
         clk_en_reg <= 1'b0;
         pin_oe_reg <= 1'b0;
      end else begin
         proc_rst_n_reg <= (state_next == ST_RUN);
         if (state_next == ST_RUN) begin
            bk_rst_n_reg <= 1'b1;
         end
         clk_en_reg <= (state_next != ST_STARTUP);
         pin_oe_reg <= (state_next == ST_ASSERT) && (drive_next != 8'h00);
      end
   end

   always @(posedge clock_i or negedge bk_rst_n) begin
      if (!bk_rst_n) begin
         cause_reg <= `RC_CAUSE_GENERAL;
      end else if (state_reg == ST_HOLD && state_next == ST_RUN) begin
         cause_reg <= pend_reg;
      end
   end

   // sticky user status
   // a new pin assertion in the read cycle wins over the clear
   always @* begin
      user_stat_next = user_stat_reg;
      if (rd_stat) begin
         user_stat_next = 1'b0;
      end
      if (in_run && pin_fall) begin
         user_stat_next = 1'b1;
      end
   end

   always @(posedge clock_i or negedge bk_rst_n) begin
      if (!bk_rst_n) begin
         user_stat_reg <= 1'b0;
      end else begin
         user_stat_reg <= user_stat_next;
      end
   end

   // backup-domain mode
   // only the backup reset clears it
   always @(posedge clock_i or negedge bk_rst_n) begin
      if (!bk_rst_n) begin
         mode_reg <= `RC_MODE_RESET;
      end else if (wr_mode) begin
         mode_reg <= {wdata_i[`RC_MODE_UIEN], wdata_i[`RC_MODE_UREN]};
      end
   end

   always @(posedge clock_i or negedge bk_rst_n) begin
      if (!bk_rst_n) begin
         irq_mask_reg <= {`RC_IRQ_N{1'b0}};
      end else if (wr_imask) begin
         irq_mask_reg <= wdata_i[`RC_IRQ_N-1:0];
      end
   end

   // interrupt events: user pin in interrupt mode, reset sequence finished
   assign irq_ev[`RC_IRQ_USER] = user_irq;
   assign irq_ev[`RC_IRQ_DONE] = (state_reg == ST_HOLD) && (state_next == ST_RUN);

   // sticky bits, write one to clear, set wins over clear
   genvar g;
   generate
      for (g = 0; g < `RC_IRQ_N; g = g + 1) begin : irq_bit
         reg stat_reg;
         assign irq_stat_next[g] = irq_ev[g] | (stat_reg & ~(wr_istat & wdata_i[g]));
         always @(posedge clock_i or negedge bk_rst_n) begin
            if (!bk_rst_n) begin
               stat_reg <= 1'b0;
            end else begin
               stat_reg <= irq_stat_next[g];
            end
         end
         assign irq_stat[g] = stat_reg;
      end
   endgenerate

   always @(posedge clock_i or negedge bk_rst_n) begin
      if (!bk_rst_n) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(irq_stat_next & irq_mask_reg);
      end
   end

   // read mux; unmapped and write-only offsets read zero
   always @* begin
      rdata_next = 32'h0000_0000;
      case (addr_i)
         `RC_OFF_STAT: begin
            rdata_next[`RC_ST_USER] = user_stat_reg;
            rdata_next[`RC_ST_CAUSE_MSB:`RC_ST_CAUSE_LSB] = cause_reg;
            rdata_next[`RC_ST_LEVEL] = pin_lvl;
         end
         `RC_OFF_MODE: begin
            rdata_next[`RC_MODE_UREN] = mode_reg[0];
            rdata_next[`RC_MODE_UIEN] = mode_reg[1];
         end
         `RC_OFF_IRQ_STAT: begin
            rdata_next[`RC_IRQ_N-1:0] = irq_stat;
         end
         `RC_OFF_IRQ_MASK: begin
            rdata_next[`RC_IRQ_N-1:0] = irq_mask_reg;
         end
         default: begin
            rdata_next = 32'h0000_0000;
         end
      endcase
   end

   // read data stand for one cycle only
   always @(posedge clock_i or negedge bk_rst_n) begin
      if (!bk_rst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else if (rd_i) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= 32'h0000_0000;
      end
   end

   assign proc_reset_n_o = proc_rst_n_reg;
   assign backup_reset_n_o = bk_rst_n_reg;
   assign proc_clk_en_o = clk_en_reg;
   assign ext_reset_pin_o = 1'b0;
   assign ext_reset_pin_oe_o = pin_oe_reg;
   assign rdata_o = rdata_reg;
   assign irq_o = irq_reg;
endmodule

// ===== rtl/rc_map.vh
// register map, field positions, codes and timing counts of the reset controller
`ifndef RC_MAP_VH
`define RC_MAP_VH

// clock rate and times
`define RC_CLK_MHZ 250
`define RC_OSC_START_US 1000
`define RC_STARTUP_CYC (`RC_OSC_START_US * `RC_CLK_MHZ)
`define RC_HOLD_CYC 2'd2
`define RC_PIN_DRIVE_CYC 8'd4

// register byte offsets
`define RC_OFF_CTRL 8'h00
`define RC_OFF_STAT 8'h04
`define RC_OFF_MODE 8'h08
`define RC_OFF_IRQ_STAT 8'h0c
`define RC_OFF_IRQ_MASK 8'h10

// control register (write only)
`define RC_CTRL_PROC_RST 0
`define RC_CTRL_EXT_RST 1

// status register
`define RC_ST_USER 0
`define RC_ST_CAUSE_LSB 8
`define RC_ST_CAUSE_MSB 10
`define RC_ST_LEVEL 16

// mode register
`define RC_MODE_UREN 0
`define RC_MODE_UIEN 4
`define RC_MODE_RESET 2'b01

// reset cause codes
`define RC_CAUSE_GENERAL 3'h0
`define RC_CAUSE_CORE 3'h1
`define RC_CAUSE_SOFT 3'h3
`define RC_CAUSE_USER 3'h4

// interrupt status and mask bits
`define RC_IRQ_USER 0
`define RC_IRQ_DONE 1
`define RC_IRQ_N 2

`endif

// ===== rtl/rc_sync2.v
// two-stage synchroniser, one per bit, with a constant reset value
`timescale 1ns/1ps
module rc_sync2 #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
   // clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // data
   input wire [WIDTH-1:0] d_i,
   output wire [WIDTH-1:0] q_o
);
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
         reg meta_reg;
         reg sync_reg;
         always @(posedge clock_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               meta_reg <= RST_VAL[g];
               sync_reg <= RST_VAL[g];
            end else begin
               meta_reg <= d_i[g];
               sync_reg <= meta_reg;
            end
         end
         assign q_o[g] = sync_reg;
      end
   endgenerate
endmodule

// ===== rtl/rc_startup_cnt.v
// startup counter: holds off until the oscillator has surely started
`timescale 1ns/1ps
module rc_startup_cnt #(
   parameter CYC = 250000
) (
   // clock and reset
   input wire clock_i,
   input wire rst_n_i,
   // control
   input wire run_i,
   output wire done_o
);
   localparam CW = $clog2(CYC + 1);
   localparam [CW-1:0] LAST = CYC - 1;
   reg [CW-1:0] cnt_reg;
   reg done_reg;
   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_reg <= {CW{1'b0}};
         done_reg <= 1'b0;
      end else if (!run_i) begin
         cnt_reg <= {CW{1'b0}};
         done_reg <= 1'b0;
      end else begin
         if (cnt_reg != LAST) begin
            cnt_reg <= cnt_reg + {{(CW-1){1'b0}}, 1'b1};
         end
         done_reg <= (cnt_reg == LAST);
      end
   end
   assign done_o = done_reg;
endmodule

// ===== dv/rc_reset_ctrl_properties.sv
// concurrent checks on the reset controller ports
`timescale 1ns/1ps
`include "rc_map.vh"
module rc_reset_ctrl_props (
   // clock, reset, supplies
   input wire clock_i,
   input wire resetn_i,
   input wire backup_por_i,
   input wire core_por_i,
   // pin and resets
   input wire ext_reset_pin_i,
   input wire ext_reset_pin_o,
   input wire ext_reset_pin_oe_o,
   input wire proc_reset_n_o,
   input wire backup_reset_n_o,
   input wire proc_clk_en_o,
   // register port
   input wire [7:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o,
   input wire irq_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!resetn_i);
   a_pin_drive_low: assert property (ext_reset_pin_oe_o |-> !ext_reset_pin_o && !proc_reset_n_o)
      else $error("pin driven outside a processor reset");
   a_clk_two_lead: assert property ($rose(backup_reset_n_o) |-> $rose(proc_reset_n_o) &&
      $past(proc_clk_en_o) && $past(proc_clk_en_o, 2) && !$past(proc_clk_en_o, 3))
      else $error("clock release does not lead reset release by two cycles");
   a_backup_first: assert property (!backup_reset_n_o |-> !proc_reset_n_o)
      else $error("processor reset released before backup reset");
   a_por_all_low: assert property (!backup_por_i |-> !proc_reset_n_o && !backup_reset_n_o &&
      !proc_clk_en_o && !irq_o)
      else $error("backup supply low without all resets");
   a_soft_request: assert property (proc_reset_n_o && wr_i && addr_i == `RC_OFF_CTRL &&
      wdata_i[`RC_CTRL_PROC_RST] |=> !proc_reset_n_o)
      else $error("software request gave no reset");
   a_core_request: assert property (proc_reset_n_o && $fell(core_por_i) |-> ##[1:4] !proc_reset_n_o)
      else $error("core supply loss gave no reset");
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
      else $error("read data outside the answer cycle");
   a_level_high: assert property (ext_reset_pin_i [*4] ##0 (rd_i && addr_i == `RC_OFF_STAT)
      |=> rdata_o[`RC_ST_LEVEL])
      else $error("pin level bit low while pin high");
   a_level_low: assert property (!ext_reset_pin_i [*4] ##0 (rd_i && addr_i == `RC_OFF_STAT)
      |=> !rdata_o[`RC_ST_LEVEL])
      else $error("pin level bit high while pin low");
   a_irq_masked: assert property (wr_i && addr_i == `RC_OFF_IRQ_MASK && wdata_i[1:0] == 2'b00
      |=> ##1 !irq_o)
      else $error("interrupt with every source masked");
   c_power_up: cover property ($rose(backup_reset_n_o));
   c_pin_drive: cover property ($rose(ext_reset_pin_oe_o));
   c_irq: cover property ($rose(irq_o));
endmodule

// ===== dv/rc_pin_model.sv
// open-drain reset pin with pull-up and a push button
`timescale 1ns/1ps
module rc_pin_model (
   // device side of the pin
   input wire pin_drive_i,
   input wire pin_oe_i,
   // button, low while pressed
   input wire press_n_i,
   output wire pin_level_o
);
   // pulled up unless the button or the device pulls low
   assign pin_level_o = press_n_i & ~(pin_oe_i & ~pin_drive_i);
endmodule

// ===== dv/rc_reset_ctrl_tb.sv
// self-checking bench for the reset controller
`timescale 1ns/1ps
`include "rc_map.vh"
module rc_reset_ctrl_tb;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic backup_por_i = 1'b1;
   logic core_por_i = 1'b1;
   logic press_n = 1'b1;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0;
   logic [31:0] seed = 32'h62cc;
   wire pin_lvl, pin_o, pin_oe, proc_rst_n, bk_rst_n, clk_en, irq;
   wire [31:0] rdata;
   int failures = 0;
   int checked = 0;
   int cause = 0;
   always #2 clock_i = ~clock_i;
   rc_pin_model i_pin (.pin_drive_i(pin_o), .pin_oe_i(pin_oe), .press_n_i(press_n),
      .pin_level_o(pin_lvl));
   rc_reset_ctrl #(.STARTUP_CYC(8)) i_dut (.clock_i(clock_i), .resetn_i(resetn_i),
      .backup_por_i(backup_por_i), .core_por_i(core_por_i), .ext_reset_pin_i(pin_lvl),
      .ext_reset_pin_o(pin_o), .ext_reset_pin_oe_o(pin_oe), .proc_reset_n_o(proc_rst_n),
      .backup_reset_n_o(bk_rst_n), .proc_clk_en_o(clk_en), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .irq_o(irq));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // expected status word from the bench's own cause tracking
   function automatic logic [31:0] st(input int u, input int l);
      return (l << `RC_ST_LEVEL) | (cause << `RC_ST_CAUSE_LSB) | (u << `RC_ST_USER);
   endfunction
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clock_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
      @(posedge clock_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clock_i);
      rd_i <= 1'b0;
      @(negedge clock_i);
      chk(what, exp, rdata);
   endtask
   task automatic wait_rst(input logic v);
      int n;
      n = 0;
      while (proc_rst_n !== v && n < 300) begin
         @(posedge clock_i);
         n++;
      end
      if (proc_rst_n !== v) begin
         $display("[FAIL] processor reset wait expected %b seen %b", v, proc_rst_n);
         failures++;
         end_sim();
      end
   endtask
   task automatic settle_irq(input logic exp);
      repeat (2) @(posedge clock_i);
      #1 chk("irq", exp, irq);
   endtask
   initial begin
      repeat (8) @(posedge clock_i);
      resetn_i <= 1'b1;
      wait_rst(1'b1);
      rd("status", `RC_OFF_STAT, st(0, 1));
      rd("mode", `RC_OFF_MODE, 32'h1);
      rd("irq status", `RC_OFF_IRQ_STAT, 32'h2);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         rd("unmapped", 8'h14 + {seed[5:0] % 6'd59, 2'b00}, 32'h0);
      end
      wr(`RC_OFF_IRQ_MASK, 32'h3);
      settle_irq(1'b1);
      wr(`RC_OFF_IRQ_STAT, 32'h2);
      settle_irq(1'b0);
      wr(`RC_OFF_MODE, 32'h11);
      wr(`RC_OFF_CTRL, 32'h3);
      #1 chk("pin drive", 1, pin_oe);
      wait_rst(1'b1);
      cause = `RC_CAUSE_SOFT;
      rd("status", `RC_OFF_STAT, st(0, 1));
      rd("mode", `RC_OFF_MODE, 32'h11);
      // pin press in interrupt mode gives no reset
      @(posedge clock_i);
      press_n <= 1'b0;
      repeat (6) @(posedge clock_i);
      press_n <= 1'b1;
      repeat (6) @(posedge clock_i);
      #1 chk("processor reset", 1, proc_rst_n);
      rd("irq status", `RC_OFF_IRQ_STAT, 32'h3);
      rd("status", `RC_OFF_STAT, st(1, 1));
      rd("status", `RC_OFF_STAT, st(0, 1));
      wr(`RC_OFF_IRQ_STAT, 32'h3);
      wr(`RC_OFF_IRQ_MASK, 32'h0);
      settle_irq(1'b0);
      // pin press with the trigger disabled
      wr(`RC_OFF_MODE, 32'h0);
      @(posedge clock_i);
      press_n <= 1'b0;
      repeat (5) @(posedge clock_i);
      rd("status", `RC_OFF_STAT, st(1, 0));
      @(posedge clock_i);
      press_n <= 1'b1;
      repeat (5) @(posedge clock_i);
      #1 chk("processor reset", 1, proc_rst_n);
      rd("status", `RC_OFF_STAT, st(0, 1));
      wr(`RC_OFF_MODE, 32'h1);
      @(posedge clock_i);
      press_n <= 1'b0;
      repeat (8) @(posedge clock_i);
      press_n <= 1'b1;
      wait_rst(1'b0);
      wait_rst(1'b1);
      cause = `RC_CAUSE_USER;
      rd("status", `RC_OFF_STAT, st(1, 1));
      @(posedge clock_i);
      core_por_i <= 1'b0;
      wait_rst(1'b0);
      repeat (4) @(posedge clock_i);
      core_por_i <= 1'b1;
      wait_rst(1'b1);
      cause = `RC_CAUSE_CORE;
      rd("status", `RC_OFF_STAT, st(0, 1));
      wr(`RC_OFF_MODE, 32'h10);
      @(posedge clock_i);
      backup_por_i <= 1'b0;
      #1 chk("backup reset", 0, bk_rst_n);
      repeat (3) @(posedge clock_i);
      backup_por_i <= 1'b1;
      wait_rst(1'b1);
      cause = `RC_CAUSE_GENERAL;
      rd("status", `RC_OFF_STAT, st(0, 1));
      rd("mode", `RC_OFF_MODE, 32'h1);
      end_sim();
   end
endmodule
bind rc_reset_ctrl rc_reset_ctrl_props i_props (.clock_i, .resetn_i, .backup_por_i,
   .core_por_i, .ext_reset_pin_i, .ext_reset_pin_o, .ext_reset_pin_oe_o, .proc_reset_n_o,
   .backup_reset_n_o, .proc_clk_en_o, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o);
